// File: design/hbap_pkg.sv
/*
  Package of the host bus autodetect port: timing figures, register
  select codes, widths and state codes.
  Assumes a 250 MHz system clock and no bus fabric around the port.
*/
package hbap_pkg;
  // System clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  // Read strobe delay figures in nanoseconds
  localparam int unsigned RD1_DELAY_NS   = 15;
  localparam int unsigned RD2_DELAY_NS   = 10;
  // Delays as whole cycles, rounded up, never below one
  localparam int unsigned RD1_CYCLES_RAW =
    (RD1_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD2_CYCLES_RAW =
    (RD2_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned RD1_CYCLES     = (RD1_CYCLES_RAW < 1) ? 1 : RD1_CYCLES_RAW;
  localparam int unsigned RD2_CYCLES     = (RD2_CYCLES_RAW < 1) ? 1 : RD2_CYCLES_RAW;
  localparam int unsigned DLY_DEPTH      = RD1_CYCLES + RD2_CYCLES;

  // Widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned REG_W  = 3;
  localparam int unsigned RAM_AW = 11;
  localparam int unsigned RAM_DEPTH = 2048;

  // Register select codes on the three register address bits
  localparam logic [2:0] SEL_STATUS   = 3'h0;
  localparam logic [2:0] SEL_DIAGNOSTIC_STATUS_REG     = 3'h1;
  localparam logic [2:0] SEL_PTR_HI   = 3'h2;
  localparam logic [2:0] SEL_PTR_LO   = 3'h3;
  localparam logic [2:0] SEL_DATA     = 3'h4;
  localparam logic [2:0] SEL_CONFIG   = 3'h6;
  localparam logic [2:0] SEL_NEXT_ID  = 3'h7;

  // Pointer high byte fields
  localparam int unsigned PTR_AUTOINC_BIT = 7;
  localparam int unsigned PTR_READ_BIT    = 6;
  localparam int unsigned PTR_HI_W        = 3;
  // Config register field
  localparam int unsigned CFG_FAST_RD_BIT = 0;

  // Reset values and pointer increment
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [10:0] PTR_ZERO = 11'h000;
  localparam logic [10:0] PTR_ONE  = 11'h001;

  // RAM arbitration state, one-hot
  typedef enum logic [2:0] {
    HBAP_RAM_IDLE  = 3'b001,
    HBAP_RAM_FETCH = 3'b010,
    HBAP_RAM_STORE = 3'b100
  } hbap_ram_t;
endpackage

// File: design/hbap_read_pulse.sv
/*
  Read pulse generator: delays the read strobe twice, samples address
  and chip select at the first delayed edge and produces qualified
  one-cycle read pulses.
  Assumes strobes synchronous to the system clock, active low.
*/
`timescale 1ns/1ps
`default_nettype none
module hbap_read_pulse (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fast_rd,      // Fast read handling on
  input  wire logic       rd_n,         // Normalised read strobe
  input  wire logic       cs_n,         // Chip select
  input  wire logic [2:0] addr,         // Register address bits
  output logic      [2:0] addr_s,       // Address used by pulses
  output logic            rd_pulse      // One-cycle qualified read
);
  logic [hbap_pkg::DLY_DEPTH-1:0] dly;  // Read strobe delay line
  logic       rd1_n;                    // First delayed read
  logic       rd2_n;                    // Second delayed read
  logic       rd_eff_n;                 // Read seen by pulse logic
  logic       rd_eff_q;                 // Previous effective read
  logic       cs_s;                     // Sampled chip select
  logic [2:0] addr_q;                   // Sampled address
  logic       cs_use;                   // Chip select used
  logic [2:0] addr_use;                 // Address used

  // Delay line; rising edge of strobe is not delayed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly <= '1;
    end else if (rd_n) begin
      dly <= '1;                        // Ends at once on release
    end else begin
      dly <= {dly[hbap_pkg::DLY_DEPTH-2:0], 1'b0};
    end
  end
  assign rd1_n = dly[hbap_pkg::RD1_CYCLES-1];
  assign rd2_n = dly[hbap_pkg::DLY_DEPTH-1];   // Pulse starts late

  // Sample address and select on the falling edge of the first copy
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= 3'h0;
      cs_s   <= 1'b0;
    end else if (!rd1_n && dly[hbap_pkg::RD1_CYCLES]) begin
      addr_q <= addr;                   // Held while read active
      cs_s   <= !cs_n;
    end
  end

  // Choose sampled or direct scheme
  always_comb begin
    rd_eff_n = fast_rd ? rd2_n : rd_n;
    cs_use   = fast_rd ? cs_s : !cs_n;
    addr_use = fast_rd ? addr_q : addr;
  end

  // Edge detect gives one pulse per read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_eff_q <= 1'b1;
      rd_pulse <= 1'b0;
      addr_s   <= 3'h0;
    end else begin
      rd_eff_q <= rd_eff_n;
      rd_pulse <= rd_eff_q && !rd_eff_n && cs_use;
      addr_s   <= addr_use;
    end
  end
endmodule
`default_nettype wire

// File: design/hbap_top.sv
/*
  Host bus autodetect port: strobe style and bus type detection,
  direct register decode, pointer access to an internal 2K byte buffer
  with prefetch, and fast bus read handling.
  Assumes host pins already synchronous to CLK_SYS and a host that
  follows the detection access order.
*/
`timescale 1ns/1ps
`default_nettype none
module hbap_top (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CHIP_SELECT_N,          // Device select
  input  wire logic       READ_STROBE_N,          // Read, or direction
  input  wire logic       WRITE_STROBE_N,         // Write, or data strobe
  input  wire logic       ADDRESS_BIT_ZERO,       // Lowest address line
  input  wire logic [2:0] REGISTER_ADDRESS_BITS,  // Register select
  input  wire logic [7:0] DATA_IN,                // Host write data
  input  wire logic       FAST_BUS_TIMING_PIN,    // Low: fast read and write
  input  wire logic       SMALL_PACKAGE,          // High: pin tied high
  input  wire logic [7:0] DIAGNOSTIC_STATUS_REG_EVENTS,            // Diagnostic event sets
  input  wire logic [7:0] NEXT_ID_IN,             // Next node identifier
  output logic      [7:0] DATA_OUT,               // Host read data
  output logic            DATA_OE,                // Data bus drive
  output logic            STROBE_STYLE_DS,        // High: direction plus strobe
  output logic            BUS_NON_MUX,            // High: non-multiplexed
  output logic            FAST_READ_ACTIVE,       // Fast read handling on
  output logic            FAST_WRITE_ACTIVE,      // Fast write handling on
  output logic            RAM_BUSY                // RAM fetch or store pending
);
  logic        style_ds;       // Detected strobe style
  logic        non_mux;        // Detected bus type
  logic        frozen;         // Detection final
  logic        style_seen;     // Strobe style decided
  logic        rd_n;           // Normalised read
  logic        wr_n;           // Normalised write
  logic        wr_q;           // Previous write
  logic        wr_pulse;       // One-cycle write
  logic        rd_pulse;       // Qualified read pulse
  logic [2:0]  rd_addr;        // Address for read pulse
  logic        pin_eff;        // Effective timing pin
  logic        fast_rd;        // Fast read handling
  logic        fast_wr;        // Fast write handling
  logic        fast_rd_bit;    // Config bit
  logic [7:0]  config_reg;     // Config register
  logic [7:0]  diagnostic_status_reg_reg;       // Diagnostic status
  logic [10:0] ptr;            // RAM pointer
  logic        ptr_autoinc;    // Auto-increment mode
  logic        ptr_read;       // Pointer set for reading
  logic [7:0]  data_reg;       // Data register
  logic [7:0]  ram [0:hbap_pkg::RAM_DEPTH-1]; // Buffer RAM
  hbap_pkg::hbap_ram_t ram_st; // RAM arbitration state
  logic        sel;            // Chip selected
  logic [7:0]  next_data_out;  // Read mux result

  // Strobes: in direction mode read strobe line is the direction
  always_comb begin
    if (style_ds) begin
      rd_n = WRITE_STROBE_N | !READ_STROBE_N;
      wr_n = WRITE_STROBE_N | READ_STROBE_N;
    end else begin
      rd_n = READ_STROBE_N;
      wr_n = WRITE_STROBE_N;
    end
  end
  assign sel = !CHIP_SELECT_N;

  // Timing mode select
  assign pin_eff     = SMALL_PACKAGE ? 1'b1 : FAST_BUS_TIMING_PIN;
  assign fast_rd_bit = config_reg[hbap_pkg::CFG_FAST_RD_BIT];
  assign fast_rd     = !pin_eff || fast_rd_bit;
  assign fast_wr     = !pin_eff;

  // Strobe style and bus type detection
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      style_ds   <= 1'b0;             // Separate strobes by default
      non_mux    <= 1'b0;             // Multiplexed by default
      frozen     <= 1'b0;
      style_seen <= 1'b0;
    end else begin
      // First write: both low lines reveal direction plus strobe
      if (!frozen && !style_seen && !WRITE_STROBE_N) begin
        style_seen <= 1'b1;          // Held until reset
        style_ds   <= !READ_STROBE_N;
      end
      // Odd access with active address line means demultiplexed
      if (!frozen && sel && (!rd_n || !wr_n) && ADDRESS_BIT_ZERO) begin
        non_mux <= 1'b1;
      end
      if (sel && !rd_n) begin
        frozen <= 1'b1;              // Final until reset
      end
    end
  end

  // Write edge detect
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_q <= 1'b1;
    end else begin
      wr_q <= wr_n;
    end
  end
  assign wr_pulse = wr_q && !wr_n && sel;

  // Qualified read pulses
  hbap_read_pulse u_rdp (
    .clk      (CLK_SYS),
    .rst      (RST),
    .fast_rd  (fast_rd),
    .rd_n     (rd_n | !sel & !fast_rd),
    .cs_n     (CHIP_SELECT_N),
    .addr     (REGISTER_ADDRESS_BITS),
    .addr_s   (rd_addr),
    .rd_pulse (rd_pulse)
  );

  // Config register
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      config_reg <= hbap_pkg::BYTE_ZERO;
    end else if (wr_pulse && REGISTER_ADDRESS_BITS == hbap_pkg::SEL_CONFIG) begin
      config_reg <= DATA_IN;
    end
  end

  // Diagnostic register: events set, read clears; set wins
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      diagnostic_status_reg_reg <= hbap_pkg::BYTE_ZERO;
    end else if (rd_pulse && rd_addr == hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG) begin
      diagnostic_status_reg_reg <= DIAGNOSTIC_STATUS_REG_EVENTS;
    end else begin
      diagnostic_status_reg_reg <= diagnostic_status_reg_reg | DIAGNOSTIC_STATUS_REG_EVENTS;
    end
  end

  // Pointer, data register and RAM arbitration; no waits to host
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ptr         <= hbap_pkg::PTR_ZERO;
      ptr_autoinc <= 1'b0;
      ptr_read    <= 1'b0;
      data_reg    <= hbap_pkg::BYTE_ZERO;
      ram_st      <= hbap_pkg::HBAP_RAM_IDLE;
    end else begin
      unique case (ram_st)
        hbap_pkg::HBAP_RAM_IDLE: begin
          ram_st <= hbap_pkg::HBAP_RAM_IDLE;
        end
        hbap_pkg::HBAP_RAM_FETCH: begin
          data_reg <= ram[ptr];                                    // Prefetch
          ram_st   <= hbap_pkg::HBAP_RAM_IDLE;
        end
        hbap_pkg::HBAP_RAM_STORE: begin
          if (ptr_autoinc) begin
            ptr <= ptr + hbap_pkg::PTR_ONE;
          end
          ram_st <= hbap_pkg::HBAP_RAM_IDLE;
        end
      endcase
      if (wr_pulse) begin
        unique case (REGISTER_ADDRESS_BITS)
          hbap_pkg::SEL_PTR_HI: begin
            ptr_autoinc <= DATA_IN[hbap_pkg::PTR_AUTOINC_BIT];
            ptr_read    <= DATA_IN[hbap_pkg::PTR_READ_BIT];
            ptr[10:8]   <= DATA_IN[hbap_pkg::PTR_HI_W-1:0];
          end
          hbap_pkg::SEL_PTR_LO: begin
            ptr[7:0] <= DATA_IN;
            if (ptr_read) begin
              ram_st <= hbap_pkg::HBAP_RAM_FETCH;
            end
          end
          hbap_pkg::SEL_DATA: begin
            data_reg <= DATA_IN;                                   // Capture first
            ram_st   <= hbap_pkg::HBAP_RAM_STORE;
          end
          default: begin
          end
        endcase
      end
      // Read of data register: advance pointer only, no reload
      if (rd_pulse && rd_addr == hbap_pkg::SEL_DATA && ptr_autoinc) begin
        ptr <= ptr + hbap_pkg::PTR_ONE;
      end
    end
  end

  // Buffer RAM commit after capture
  always_ff @(posedge CLK_SYS) begin
    if (ram_st == hbap_pkg::HBAP_RAM_STORE) begin
      ram[ptr] <= data_reg;
    end
  end

  // Read mux on undelayed address only; select is not decoded
  always_comb begin
    unique case (REGISTER_ADDRESS_BITS)
      hbap_pkg::SEL_STATUS:  next_data_out = {5'h00, fast_rd, non_mux, style_ds};
      hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG:    next_data_out = diagnostic_status_reg_reg;
      hbap_pkg::SEL_PTR_HI:  next_data_out = {ptr_autoinc, ptr_read, 3'h0, ptr[10:8]};
      hbap_pkg::SEL_PTR_LO:  next_data_out = ptr[7:0];
      hbap_pkg::SEL_DATA:    next_data_out = data_reg;
      hbap_pkg::SEL_CONFIG:  next_data_out = config_reg;
      hbap_pkg::SEL_NEXT_ID: next_data_out = NEXT_ID_IN;
      default:               next_data_out = hbap_pkg::BYTE_ZERO;
    endcase
  end

  // Registered outputs
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      DATA_OUT          <= hbap_pkg::BYTE_ZERO;
      DATA_OE           <= 1'b0;
      STROBE_STYLE_DS   <= 1'b0;
      BUS_NON_MUX       <= 1'b0;
      FAST_READ_ACTIVE  <= 1'b0;
      FAST_WRITE_ACTIVE <= 1'b0;
      RAM_BUSY          <= 1'b0;
    end else begin
      DATA_OUT          <= next_data_out;
      DATA_OE           <= sel && !rd_n;
      STROBE_STYLE_DS   <= style_ds;
      BUS_NON_MUX       <= non_mux;
      FAST_READ_ACTIVE  <= fast_rd;
      FAST_WRITE_ACTIVE <= fast_wr;
      RAM_BUSY          <= ram_st != hbap_pkg::HBAP_RAM_IDLE;
    end
  end
endmodule
`default_nettype wire

// File: verification/hbap_props.sv
/*
  Port checker for the host bus autodetect port: detection freeze,
  read drive, RAM fetch and fast bus mode selection.
  Assumes it is bound to hbap_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module hbap_props (
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       CHIP_SELECT_N,
  input wire logic       READ_STROBE_N,
  input wire logic       WRITE_STROBE_N,
  input wire logic [2:0] REGISTER_ADDRESS_BITS,
  input wire logic [7:0] DATA_IN,
  input wire logic       FAST_BUS_TIMING_PIN,
  input wire logic       SMALL_PACKAGE,
  input wire logic       DATA_OE,
  input wire logic       STROBE_STYLE_DS,
  input wire logic       BUS_NON_MUX,
  input wire logic       FAST_READ_ACTIVE,
  input wire logic       FAST_WRITE_ACTIVE,
  input wire logic       RAM_BUSY
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Selected read and write, decoded per detected strobe style
  wire rd_now = !CHIP_SELECT_N && (STROBE_STYLE_DS ? (READ_STROBE_N && !WRITE_STROBE_N)
                                                   : (!READ_STROBE_N && WRITE_STROBE_N));
  wire wr_now = !CHIP_SELECT_N && !WRITE_STROBE_N && (STROBE_STYLE_DS ^ READ_STROBE_N);
  logic [1:0] read_age;  // Cycles since first read, saturates at 3
  // Age counter; margin lets the odd read itself settle the bus type
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      read_age <= 2'h0;
    end else if (read_age != 2'h3 && (read_age != 2'h0 || rd_now)) begin
      read_age <= read_age + 2'h1;
    end
  end
  logic ptr_rd_mode;     // Pointer last set up for reading
  // Mirror of the read flag of the pointer high byte; only read loads fetch
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ptr_rd_mode <= 1'b0;
    end else if (wr_now && $fell(WRITE_STROBE_N)
                 && REGISTER_ADDRESS_BITS == hbap_pkg::SEL_PTR_HI) begin
      ptr_rd_mode <= DATA_IN[hbap_pkg::PTR_READ_BIT];
    end
  end
  sequence host_read;
    rd_now;
  endsequence
  sequence ptr_lo_write;
    wr_now && $fell(WRITE_STROBE_N) && ptr_rd_mode
      && REGISTER_ADDRESS_BITS == hbap_pkg::SEL_PTR_LO;
  endsequence
  sequence fast_pin_low;
    (!FAST_BUS_TIMING_PIN && !SMALL_PACKAGE) [*3];
  endsequence
  chk_oe_on_read: assert property (host_read |=> DATA_OE)
    else $error("read not driven");
  chk_oe_idle_off: assert property (CHIP_SELECT_N |=> !DATA_OE)
    else $error("bus driven while idle");
  chk_style_kept: assert property (STROBE_STYLE_DS |=> STROBE_STYLE_DS)
    else $error("strobe style lost");
  chk_bus_type_kept: assert property (BUS_NON_MUX |=> BUS_NON_MUX)
    else $error("bus type lost");
  chk_detect_frozen: assert property (read_age == 2'h3 |->
    $stable(STROBE_STYLE_DS) && $stable(BUS_NON_MUX))
    else $error("detection moved after read");
  chk_fetch_starts: assert property (ptr_lo_write |-> ##[1:3] RAM_BUSY)
    else $error("no fetch after pointer load");
  chk_ram_no_wait: assert property (RAM_BUSY |-> ##[1:4] !RAM_BUSY)
    else $error("RAM access too long");
  chk_fast_pin_low: assert property (fast_pin_low |-> FAST_READ_ACTIVE && FAST_WRITE_ACTIVE)
    else $error("fast modes off with pin low");
  chk_fast_pin_high: assert property ((FAST_BUS_TIMING_PIN || SMALL_PACKAGE) [*3]
    |-> !FAST_WRITE_ACTIVE)
    else $error("fast write on with pin high");
  chk_write_needs_rd: assert property (FAST_WRITE_ACTIVE |-> FAST_READ_ACTIVE)
    else $error("fast write without fast read");
endmodule
bind hbap_top hbap_props hbap_props_inst (.CLK_SYS, .RST, .CHIP_SELECT_N, .READ_STROBE_N,
  .WRITE_STROBE_N, .REGISTER_ADDRESS_BITS, .DATA_IN, .FAST_BUS_TIMING_PIN, .SMALL_PACKAGE,
  .DATA_OE,
  .STROBE_STYLE_DS, .BUS_NON_MUX, .FAST_READ_ACTIVE, .FAST_WRITE_ACTIVE, .RAM_BUSY);
`default_nettype wire

// File: verification/hbap_host_model.sv
/*
  Host processor model: drives write and read cycles in either strobe
  style at the falling clock edge.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module hbap_host_model (
  input  wire logic       clk,
  input  wire logic       ds_style,  // High: direction plus data strobe
  input  wire logic [7:0] rdata,     // Device read data
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            a0,
  output logic      [2:0] addr,
  output logic      [7:0] wdata
);
  // Idle bus at time zero
  initial begin
    {cs_n, rd_n, wr_n, a0, addr, wdata} = {3'h7, 12'h000};
  end
  // Released lines flip so stale values never look valid
  task automatic release_bus();
    {cs_n, rd_n, wr_n} = 3'h7;
    {a0, addr, wdata} = ~{a0, addr, wdata};
    repeat (3) @(negedge clk);  // Spacing for RAM accesses
  endtask
  // Write cycle; in direction style the direction line is low
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic odd);
    @(negedge clk);
    {addr, a0, wdata, cs_n, wr_n} = {a, odd, d, 2'b00};
    rd_n = ~ds_style;
    repeat (2) @(negedge clk);
    release_bus();
  endtask
  // Read cycle, strobe widened to cover the fast mode delays
  task automatic rd(input logic [2:0] a, input logic odd, output logic [7:0] d);
    @(negedge clk);
    {addr, a0, cs_n, rd_n, wr_n} = {a, odd, 1'b0, ds_style, ~ds_style};
    @(negedge clk);
    d = rdata;  // Registered one cycle after select
    repeat (7) @(negedge clk);
    release_bus();
  endtask
endmodule
`default_nettype wire

// File: verification/tb_hbap_top.sv
/*
  Self-checking bench for hbap_top: detection in both strobe styles,
  fast mode table, diagnostic clear, next id and pointer RAM access.
  Assumes hbap_props is bound and the host model drives the bus.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_hbap_top;
  logic       clk_sys, rst, ds_style, fast_pin, small_pkg;
  logic       cs_n, rd_n, wr_n, a0, oe, style_ds, non_mux, fast_rd, fast_wr, ram_busy;
  logic [2:0] addr;
  logic [7:0] wdata, diagnostic_status_reg_ev, data_out, rb;
  logic [10:0] p;
  int         num_errors = 0;
  int         checks_done = 0;
  int         cycles = 0;
  // Rows: pin, small package, config bit, fast read, fast write
  localparam logic [0:7][4:0] MODES = {5'b00011, 5'b00111, 5'b01000, 5'b01110,
                                       5'b10000, 5'b10110, 5'b11000, 5'b11110};
  hbap_host_model hbap_host_model_inst (.clk(clk_sys), .ds_style(ds_style), .rdata(data_out),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .a0(a0), .addr(addr), .wdata(wdata));
  hbap_top hbap_top_inst (.CLK_SYS(clk_sys), .RST(rst), .CHIP_SELECT_N(cs_n),
    .READ_STROBE_N(rd_n), .WRITE_STROBE_N(wr_n), .ADDRESS_BIT_ZERO(a0),
    .REGISTER_ADDRESS_BITS(addr), .DATA_IN(wdata), .FAST_BUS_TIMING_PIN(fast_pin),
    .SMALL_PACKAGE(small_pkg), .DIAGNOSTIC_STATUS_REG_EVENTS(diagnostic_status_reg_ev), .NEXT_ID_IN(8'hc3),
    .DATA_OUT(data_out), .DATA_OE(oe), .STROBE_STYLE_DS(style_ds), .BUS_NON_MUX(non_mux),
    .FAST_READ_ACTIVE(fast_rd), .FAST_WRITE_ACTIVE(fast_wr), .RAM_BUSY(ram_busy));
  // 250 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Reset held four cycles, released at a falling edge
  task automatic do_reset();
    rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
  endtask
  // Hang guard, well above the expected run of some 700 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {ds_style, fast_pin, small_pkg, diagnostic_status_reg_ev} = {3'b010, 8'h00};
    do_reset();
    check({style_ds, non_mux, fast_rd}, 3'b000);
    check({oe, ram_busy}, 2'b00);
    // Odd write then odd read settles both detections
    hbap_host_model_inst.wr(hbap_pkg::SEL_CONFIG, 8'h00, 1'b1);
    hbap_host_model_inst.rd(hbap_pkg::SEL_STATUS, 1'b1, rb);
    check({style_ds, non_mux, rb[1:0]}, 4'b0110);
    // Fast mode table, with config readback
    for (int i = 0; i < 8; i++) begin
      {fast_pin, small_pkg} = MODES[i][4:3];
      hbap_host_model_inst.wr(hbap_pkg::SEL_CONFIG, {7'h00, MODES[i][2]}, 1'b0);
      hbap_host_model_inst.rd(hbap_pkg::SEL_CONFIG, 1'b0, rb);
      check(rb[0], MODES[i][2]);
      hbap_host_model_inst.rd(hbap_pkg::SEL_STATUS, 1'b0, rb);
      check({fast_rd, fast_wr, rb[2]}, {MODES[i][1:0], MODES[i][1]});
    end
    check(non_mux, 1'b1);  // Even accesses after the read
    hbap_host_model_inst.wr(hbap_pkg::SEL_CONFIG, 8'h00, 1'b0);
    small_pkg = 1'b0;
    // Normal then fast read handling
    for (int j = 0; j < 2; j++) begin
      fast_pin = (j == 0);
      @(negedge clk_sys) diagnostic_status_reg_ev = 8'h5a;
      @(negedge clk_sys) diagnostic_status_reg_ev = 8'h00;
      hbap_host_model_inst.rd(hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG, 1'b0, rb);
      check(rb, 8'h5a);
      hbap_host_model_inst.rd(hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG, 1'b0, rb);
      check(rb, 8'h00);  // Cleared by the read
      hbap_host_model_inst.rd(hbap_pkg::SEL_NEXT_ID, 1'b0, rb);
      check(rb, 8'hc3);
      // Auto-increment write across a 256 byte boundary
      hbap_host_model_inst.wr(hbap_pkg::SEL_PTR_HI, 8'h82, 1'b0);
      hbap_host_model_inst.wr(hbap_pkg::SEL_PTR_LO, 8'hfe, 1'b0);
      for (int k = 0; k < 3; k++) hbap_host_model_inst.wr(hbap_pkg::SEL_DATA, 8'(16 * j + k), 1'b0);
      // Fixed pointer readback, read twice without reload
      for (int k = 0; k < 3; k++) begin
        p = 11'h2fe + 11'(k);
        hbap_host_model_inst.wr(hbap_pkg::SEL_PTR_HI, {5'b01000, p[10:8]}, 1'b0);
        hbap_host_model_inst.wr(hbap_pkg::SEL_PTR_LO, p[7:0], 1'b0);
        hbap_host_model_inst.rd(hbap_pkg::SEL_DATA, 1'b0, rb);
        check(rb, 8'(16 * j + k));
        hbap_host_model_inst.rd(hbap_pkg::SEL_DATA, 1'b0, rb);
        check(rb, 8'(16 * j + k));
      end
    end
    // Second reset in mid-run, then direction plus strobe host
    ds_style = 1'b1;
    do_reset();
    check({style_ds, non_mux}, 2'b00);
    hbap_host_model_inst.wr(hbap_pkg::SEL_CONFIG, 8'h00, 1'b0);
    hbap_host_model_inst.rd(hbap_pkg::SEL_STATUS, 1'b0, rb);
    check({style_ds, non_mux, rb[1:0]}, 4'b1001);
    hbap_host_model_inst.wr(hbap_pkg::SEL_CONFIG, 8'h00, 1'b1);
    check({style_ds, non_mux}, 2'b10);  // Frozen after the read
    @(negedge clk_sys) diagnostic_status_reg_ev = 8'h81;
    @(negedge clk_sys) diagnostic_status_reg_ev = 8'h00;
    hbap_host_model_inst.rd(hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG, 1'b0, rb);
    check(rb, 8'h81);
    hbap_host_model_inst.rd(hbap_pkg::SEL_DIAGNOSTIC_STATUS_REG, 1'b0, rb);
    check(rb, 8'h00);
    conclude();
  end
endmodule
`default_nettype wire
